/* ssc_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

`define SSC_ADDR_W          8
`define SSC_OFF_CTRL        8'h00
`define SSC_OFF_STATUS      8'h04
`define SSC_OFF_IRQ_STAT    8'h08
`define SSC_OFF_IRQ_MASK    8'h0C
`define SSC_OFF_STANDBY     8'h10
`define SSC_OFF_FRONT       8'h14
`define SSC_OFF_DBL_REAR    8'h18
`define SSC_OFF_DBL_FRONT   8'h1C
`define SSC_OFF_BELT        8'h20
`define SSC_OFF_TIMEOUT     8'h24

`define SSC_CTRL_START      0
`define SSC_CTRL_MODE_LO    1
`define SSC_CTRL_MODE_HI    2
`define SSC_CTRL_REHOME     3

`define SSC_ST_EMPTY        4
`define SSC_ST_TOP          5
`define SSC_ST_LOCK         6
`define SSC_ST_READY        7
`define SSC_ST_ERROR        8

`define SSC_IRQ_DONE        0
`define SSC_IRQ_ERR         1
`define SSC_IRQ_EMPTY       2

`define SSC_RST_STANDBY     16'h0100
`define SSC_RST_FRONT       16'h0800
`define SSC_RST_DBL_REAR    16'h0300
`define SSC_RST_DBL_FRONT   16'h0600
`define SSC_RST_BELT        16'h0040
`define SSC_RST_TIMEOUT     16'h1000

`define SSC_CLK_PERIOD_NS   20
`define SSC_STEP_PERIOD_US  1000
`define SSC_STEP_CYCLES     ((`SSC_STEP_PERIOD_US * 1000) / `SSC_CLK_PERIOD_NS)

`endif

/* ssc_pkg.sv */
// types for the stapler sequence controller
package ssc_pkg;

    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_HOME  = 4'h1,
        ST_TOSB  = 4'h3,
        ST_READY = 4'h2,
        ST_GDOWN = 4'h6,
        ST_MOVE  = 4'h7,
        ST_CAMOF = 4'h5,
        ST_CAMON = 4'h4,
        ST_DELIV = 4'hC,
        ST_DCNT  = 4'hD,
        ST_RET   = 4'hF,
        ST_ERR   = 4'hE
    } ssc_state_e;

    typedef enum logic [1:0] {
        MODE_REAR   = 2'h0,
        MODE_FRONT  = 2'h1,
        MODE_CENTER = 2'h2,
        MODE_SADDLE = 2'h3
    } ssc_mode_e;

    typedef logic [15:0] ssc_word_t;

endpackage : ssc_pkg

/* ssc_stapler_ctrl.sv */
// stapler carriage, cam and post-staple delivery sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"

// Summary of operation
// - home carriage frontward after reset or door close
// - stop slide motor when home sensor sees plate
// - then step rearward configured count to standby
// - lower swing guide with paddle motor reversed
// - carriage waits at rear standby between jobs
// - host command moves carriage to mode position
// - rear single staples at standby without moving
// - front single goes out, staples, returns
// - double modes staple rear then front
// - staple cycle is one cam revolution
// - cam off home while ready: run motor forward until on
// - staple motor never runs without interlock
// - sample staple empty and top sensors
// - after stapling run delivery motor forward
// - belt sensor off plus count raises guide
// - guide rise starts carriage return to standby
module ssc_stapler_ctrl #(
    parameter int STEP_CYCLES = `SSC_STEP_CYCLES
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_b_i,
    input  wire logic [`SSC_ADDR_W-1:0]    reg_addr_i,
    input  wire logic [31:0]               reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [31:0]               reg_rdata_o,
    input  wire logic                      carriage_home_sensor_i,
    input  wire logic                      cam_home_sensor_i,
    input  wire logic                      staple_empty_sensor_i,
    input  wire logic                      staple_top_sensor_i,
    input  wire logic                      staple_safety_interlock_i,
    input  wire logic                      delivery_belt_home_sensor_i,
    input  wire logic                      swing_guide_home_sensor_i,
    input  wire logic                      front_door_closed_i,
    output logic                           carriage_slide_step_o,
    output logic                           carriage_slide_rear_o,
    output logic                           paddle_motor_step_o,
    output logic                           paddle_motor_rev_o,
    output logic                           delivery_motor_step_o,
    output logic                           staple_fold_motor_fwd_o,
    output logic                           irq_o
);
    import ssc_pkg::*;

    localparam int NS = 8;
    localparam logic [NS-1:0] SYNC_RST = 8'h80;

    function automatic logic hit(input logic [`SSC_ADDR_W-1:0] a,
                                 input logic [`SSC_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // two-flop synchronisers for all pin inputs
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] sync1_r;
    logic [NS-1:0] sync2_r;
    assign pin_raw = {front_door_closed_i, swing_guide_home_sensor_i,
                      delivery_belt_home_sensor_i,
                      staple_safety_interlock_i, staple_top_sensor_i,
                      staple_empty_sensor_i, cam_home_sensor_i,
                      carriage_home_sensor_i};
    genvar g;
    generate
        for (g = 0; g < NS; g++)
        begin : g_sync
            always_ff @(posedge ref_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    sync1_r[g] <= SYNC_RST[g];
                    sync2_r[g] <= SYNC_RST[g];
                end
                else
                begin
                    sync1_r[g] <= pin_raw[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    logic car_home_s;
    logic cam_home_s;
    logic empty_s;
    logic top_s;
    logic lock_s;
    logic belt_s;
    logic guide_s;
    logic door_s;
    assign car_home_s = sync2_r[0];
    assign cam_home_s = sync2_r[1];
    assign empty_s    = sync2_r[2];
    assign top_s      = sync2_r[3];
    assign lock_s     = sync2_r[4];
    assign belt_s     = sync2_r[5];
    assign guide_s    = sync2_r[6];
    assign door_s     = sync2_r[7];

    // registers
    ssc_word_t standby_r;
    ssc_word_t front_r;
    ssc_word_t dbl_rear_r;
    ssc_word_t dbl_front_r;
    ssc_word_t belt_r;
    ssc_word_t timeout_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    ssc_mode_e  mode_r;
    logic       start_p;
    logic       rehome_p;
    logic       wr_ctrl;

    assign wr_ctrl  = reg_wr_i && hit(reg_addr_i, `SSC_OFF_CTRL);
    assign start_p  = wr_ctrl && reg_wdata_i[`SSC_CTRL_START];
    assign rehome_p = wr_ctrl && reg_wdata_i[`SSC_CTRL_REHOME];

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            standby_r   <= `SSC_RST_STANDBY;
            front_r     <= `SSC_RST_FRONT;
            dbl_rear_r  <= `SSC_RST_DBL_REAR;
            dbl_front_r <= `SSC_RST_DBL_FRONT;
            belt_r      <= `SSC_RST_BELT;
            timeout_r   <= `SSC_RST_TIMEOUT;
            irq_mask_r  <= 3'h0;
        end
        else if (reg_wr_i)
        begin
            if (hit(reg_addr_i, `SSC_OFF_STANDBY))
                standby_r <= reg_wdata_i[15:0];
            if (hit(reg_addr_i, `SSC_OFF_FRONT))
                front_r <= reg_wdata_i[15:0];
            if (hit(reg_addr_i, `SSC_OFF_DBL_REAR))
                dbl_rear_r <= reg_wdata_i[15:0];
            if (hit(reg_addr_i, `SSC_OFF_DBL_FRONT))
                dbl_front_r <= reg_wdata_i[15:0];
            if (hit(reg_addr_i, `SSC_OFF_BELT))
                belt_r <= reg_wdata_i[15:0];
            if (hit(reg_addr_i, `SSC_OFF_TIMEOUT))
                timeout_r <= reg_wdata_i[15:0];
            if (hit(reg_addr_i, `SSC_OFF_IRQ_MASK))
                irq_mask_r <= reg_wdata_i[2:0];
        end
    end

    // step rate enable
    logic [31:0] div_r;
    logic        tick;
    assign tick = (div_r == 32'(STEP_CYCLES - 1));
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            div_r <= 32'h0;
        else if (tick)
            div_r <= 32'h0;
        else
            div_r <= div_r + 32'h1;
    end

    // sequencer
    ssc_state_e state_r;
    ssc_state_e state_nxt;
    ssc_word_t  pos_r;
    ssc_word_t  target;
    ssc_word_t  tmo_r;
    ssc_word_t  cnt_r;
    logic       second_r;
    logic       door_d_r;
    logic       door_rise;
    logic       at_target;
    logic       tmo_hit;
    logic       slide_go;
    logic       slide_rear;
    logic       accept;

    assign door_rise = door_s && !door_d_r;
    assign accept    = start_p && (state_r == ST_READY);
    assign tmo_hit   = (state_r == ST_HOME || state_r == ST_CAMOF ||
                        state_r == ST_CAMON) && (tmo_r == timeout_r);

    always_comb
    begin
        target = standby_r;
        if (state_r == ST_MOVE)
        begin
            case (mode_r)
                MODE_FRONT:  target = front_r;
                MODE_CENTER,
                MODE_SADDLE: target = second_r ? dbl_front_r : dbl_rear_r;
                default:     target = standby_r;
            endcase
        end
    end
    assign at_target = (pos_r == target);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: state_nxt = ST_HOME;
            ST_HOME:
                if (car_home_s)
                    state_nxt = ST_TOSB;
            ST_TOSB:
                if (at_target)
                    state_nxt = ST_READY;
            ST_READY:
                if (accept)
                    state_nxt = ST_GDOWN;
            ST_GDOWN:
                if (lock_s)
                    state_nxt = ST_MOVE;
            ST_MOVE:
                if (at_target)
                    state_nxt = ST_CAMOF;
            ST_CAMOF:
                if (!cam_home_s)
                    state_nxt = ST_CAMON;
            ST_CAMON:
                if (cam_home_s)
                begin
                    if ((mode_r == MODE_CENTER || mode_r == MODE_SADDLE)
                        && !second_r)
                        state_nxt = ST_MOVE;
                    else
                        state_nxt = ST_DELIV;
                end
            ST_DELIV:
                if (!belt_s)
                    state_nxt = ST_DCNT;
            ST_DCNT:
                if (cnt_r == belt_r)
                    state_nxt = ST_RET;
            ST_RET:
                if (at_target && guide_s)
                    state_nxt = ST_READY;
            ST_ERR:  state_nxt = ST_ERR;
            default: state_nxt = ST_RESET;
        endcase
        if (tmo_hit)
            state_nxt = ST_ERR;
        if (door_rise || rehome_p)
            state_nxt = ST_HOME;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_r  <= ST_RESET;
            door_d_r <= 1'b1;
        end
        else
        begin
            state_r  <= state_nxt;
            door_d_r <= door_s;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mode_r   <= MODE_REAR;
            second_r <= 1'b0;
        end
        else if (accept)
        begin
            mode_r   <= ssc_mode_e'(reg_wdata_i[`SSC_CTRL_MODE_HI:
                                                `SSC_CTRL_MODE_LO]);
            second_r <= 1'b0;
        end
        else if (state_r == ST_CAMON && cam_home_s)
            second_r <= 1'b1;
    end

    // watchdog and delivery pulse count
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tmo_r <= 16'h0;
        else if (state_nxt != state_r)
            tmo_r <= 16'h0;
        else if (tick && !tmo_hit)
            tmo_r <= tmo_r + 16'h1;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_r <= 16'h0;
        else if (state_r != ST_DCNT)
            cnt_r <= 16'h0;
        else if (tick && cnt_r != belt_r)
            cnt_r <= cnt_r + 16'h1;
    end

    // carriage slide motion
    always_comb
    begin
        slide_go   = 1'b0;
        slide_rear = 1'b0;
        case (state_r)
            ST_HOME:
                slide_go = !car_home_s;
            ST_TOSB, ST_MOVE, ST_RET:
            begin
                slide_go   = !at_target;
                slide_rear = (pos_r < target);
            end
            default: slide_go = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pos_r <= 16'h0;
        else if (state_r == ST_HOME)
            pos_r <= 16'h0;
        else if (tick && slide_go)
            pos_r <= slide_rear ? pos_r + 16'h1 : pos_r - 16'h1;
    end

    // motor outputs
    logic cam_want;
    assign cam_want = (state_r == ST_CAMOF || state_r == ST_CAMON) ||
                      (state_r == ST_READY && !cam_home_s);

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            carriage_slide_step_o   <= 1'b0;
            carriage_slide_rear_o   <= 1'b0;
            paddle_motor_step_o     <= 1'b0;
            paddle_motor_rev_o      <= 1'b0;
            delivery_motor_step_o   <= 1'b0;
            staple_fold_motor_fwd_o <= 1'b0;
        end
        else
        begin
            carriage_slide_step_o   <= tick && slide_go;
            carriage_slide_rear_o   <= slide_rear;
            paddle_motor_step_o     <= tick &&
                ((state_r == ST_GDOWN && !lock_s) ||
                 (state_r == ST_RET && !guide_s));
            paddle_motor_rev_o      <= (state_r == ST_GDOWN);
            delivery_motor_step_o   <= tick &&
                (state_r == ST_DELIV || state_r == ST_DCNT ||
                 state_r == ST_RET);
            staple_fold_motor_fwd_o <= cam_want && lock_s && !tmo_hit &&
                (state_nxt != ST_ERR);
        end
    end

    // interrupts: set wins over write-one-to-clear
    logic [2:0] irq_set;
    logic       empty_d_r;
    assign irq_set = {empty_s && !empty_d_r,
                      state_nxt == ST_ERR && state_r != ST_ERR,
                      state_r == ST_RET && state_nxt == ST_READY};
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            irq_stat_r <= 3'h0;
            empty_d_r  <= 1'b0;
        end
        else
        begin
            empty_d_r <= empty_s;
            if (reg_wr_i && hit(reg_addr_i, `SSC_OFF_IRQ_STAT))
                irq_stat_r <= (irq_stat_r & ~reg_wdata_i[2:0]) | irq_set;
            else
                irq_stat_r <= irq_stat_r | irq_set;
        end
    end
    assign irq_o = |(irq_stat_r & irq_mask_r);

    // read port, data in the cycle after the strobe
    ssc_word_t status_w;
    always_comb
    begin
        status_w = 16'h0;
        status_w[3:0] = state_r;
        status_w[`SSC_ST_EMPTY] = empty_s;
        status_w[`SSC_ST_TOP]   = top_s;
        status_w[`SSC_ST_LOCK]  = lock_s;
        status_w[`SSC_ST_READY] = (state_r == ST_READY);
        status_w[`SSC_ST_ERROR] = (state_r == ST_ERR);
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= 32'h0;
        else if (!reg_rd_i)
            reg_rdata_o <= 32'h0;
        else
        begin
            case (reg_addr_i)
                `SSC_OFF_CTRL:      reg_rdata_o <= {29'h0, mode_r, 1'b0};
                `SSC_OFF_STATUS:    reg_rdata_o <= {16'h0, status_w};
                `SSC_OFF_IRQ_STAT:  reg_rdata_o <= {29'h0, irq_stat_r};
                `SSC_OFF_IRQ_MASK:  reg_rdata_o <= {29'h0, irq_mask_r};
                `SSC_OFF_STANDBY:   reg_rdata_o <= {16'h0, standby_r};
                `SSC_OFF_FRONT:     reg_rdata_o <= {16'h0, front_r};
                `SSC_OFF_DBL_REAR:  reg_rdata_o <= {16'h0, dbl_rear_r};
                `SSC_OFF_DBL_FRONT: reg_rdata_o <= {16'h0, dbl_front_r};
                `SSC_OFF_BELT:      reg_rdata_o <= {16'h0, belt_r};
                `SSC_OFF_TIMEOUT:   reg_rdata_o <= {16'h0, timeout_r};
                default:            reg_rdata_o <= 32'h0;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_cam_done;
        state_r == ST_CAMON && cam_home_s && !tmo_hit && !door_rise
            && !rehome_p;
    endsequence

    property p_home_front;
        (state_r == ST_HOME && slide_go && tick) |=>
            carriage_slide_step_o && !carriage_slide_rear_o;
    endproperty
    a_home_front: assert property (p_home_front)
        else $error("homing step not toward front");

    property p_home_stop;
        (state_r == ST_HOME && car_home_s && !tmo_hit && !door_rise &&
            !rehome_p) |=> state_r == ST_TOSB ##1 !(carriage_slide_step_o &&
                !carriage_slide_rear_o);
    endproperty
    a_home_stop: assert property (p_home_stop)
        else $error("slide not stopped at home");

    property p_ready_pos;
        $rose(state_r == ST_READY) |-> pos_r == standby_r;
    endproperty
    a_ready_pos: assert property (p_ready_pos)
        else $error("ready away from standby");

    property p_gdown;
        accept && !door_rise && !rehome_p |=> state_r == ST_GDOWN ##1
            paddle_motor_rev_o;
    endproperty
    a_gdown: assert property (p_gdown)
        else $error("guide not lowered on command");

    property p_rear_still;
        (state_r == ST_MOVE && mode_r == MODE_REAR) |-> !slide_go;
    endproperty
    a_rear_still: assert property (p_rear_still)
        else $error("carriage moved in rear single");

    property p_lock;
        staple_fold_motor_fwd_o |-> $past(lock_s);
    endproperty
    a_lock: assert property (p_lock)
        else $error("staple motor without interlock");

    property p_deliver;
        s_cam_done ##0 (second_r || mode_r == MODE_REAR ||
            mode_r == MODE_FRONT) |=> state_r == ST_DELIV;
    endproperty
    a_deliver: assert property (p_deliver)
        else $error("delivery not started after staple");

    property p_dbl_front;
        s_cam_done ##0 (!second_r && (mode_r == MODE_CENTER ||
            mode_r == MODE_SADDLE)) |=> state_r == ST_MOVE && second_r;
    endproperty
    a_dbl_front: assert property (p_dbl_front)
        else $error("front staple not next");

    property p_cam_restore;
        (state_r == ST_READY && !cam_home_s && lock_s && !accept &&
            !door_rise && !rehome_p) |=> staple_fold_motor_fwd_o;
    endproperty
    a_cam_restore: assert property (p_cam_restore)
        else $error("cam not returned to home");

    property p_ret;
        (state_r == ST_DCNT && cnt_r == belt_r && !door_rise && !rehome_p)
            |=> state_r == ST_RET;
    endproperty
    a_ret: assert property (p_ret)
        else $error("return not started with guide rise");

    property p_tmo;
        tmo_hit && !door_rise && !rehome_p |=>
            state_r == ST_ERR ##1 !staple_fold_motor_fwd_o;
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("timeout not handled");

endmodule : ssc_stapler_ctrl
`default_nettype wire

/* ssc_mech_model.sv */
// mechanism model: carriage, cam, swing guide and delivery belt
`timescale 1ns/1ps
`default_nettype none
module ssc_mech_model (
    input  wire logic clk_i,
    input  wire logic slide_step_i,
    input  wire logic slide_rear_i,
    input  wire logic paddle_step_i,
    input  wire logic paddle_rev_i,
    input  wire logic deliv_step_i,
    input  wire logic cam_fwd_i,
    input  wire logic cam_stall_i,
    output logic      carr_home_o,
    output logic      cam_home_o,
    output logic      lock_o,
    output logic      belt_home_o,
    output logic      guide_home_o
);
    int pos     = 40;
    int min_pos = 40;
    int homes   = 0;
    int cam     = 0;
    int guide   = 0;
    int belt    = 0;
    int dsteps  = 0;
    always @(posedge clk_i)
    begin
        if (slide_step_i)
            pos <= slide_rear_i ? pos + 1 : pos - 1;
        if (slide_step_i && !slide_rear_i && pos == 1)
            homes <= homes + 1;
        if (pos < min_pos)
            min_pos <= pos;
        if (cam_fwd_i && !cam_stall_i)
            cam <= (cam + 1) % 40;
        if (paddle_step_i && paddle_rev_i && guide < 6)
            guide <= guide + 1;
        if (paddle_step_i && !paddle_rev_i && guide > 0)
            guide <= guide - 1;
        if (deliv_step_i)
        begin
            belt <= (belt + 1) % 64;
            dsteps <= dsteps + 1;
        end
    end
    assign carr_home_o  = pos <= 0;
    assign cam_home_o   = cam < 10;
    assign lock_o       = guide == 6;
    assign guide_home_o = guide == 0;
    assign belt_home_o  = belt < 2;
endmodule : ssc_mech_model
`default_nettype wire

/* tb_stapler_sequence_control.sv */
// self-checking bench for the stapler sequence controller
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"
module tb_stapler_sequence_control;
    import ssc_pkg::*;
    logic        ref_clk_i, rst_b_i, reg_wr_i, reg_rd_i, irq_o;
    logic [7:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, last_rd;
    logic        carr_home, cam_home, lock, belt_home, guide_home;
    logic        empty, top, door, stall, rd_d, fwd_d;
    logic        slide_step, slide_rear, pad_step, pad_rev, dlv, cam_fwd;
    logic [31:0] exp_q[$], msk_q[$];
    int          stap_q[$];
    int          n_errors, checks_done, seed, belt_n, d0;
    logic [7:0]  offs[8] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
                             8'h0C, 8'h08};
    logic [31:0] vals[8] = '{`SSC_RST_STANDBY, `SSC_RST_FRONT,
                             `SSC_RST_DBL_REAR, `SSC_RST_DBL_FRONT,
                             `SSC_RST_BELT, `SSC_RST_TIMEOUT, 0, 0};
    int          pos1[4] = '{256, 100, 200, 200};
    ssc_stapler_ctrl #(.STEP_CYCLES(4)) dut (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .carriage_home_sensor_i(carr_home), .cam_home_sensor_i(cam_home),
        .staple_empty_sensor_i(empty), .staple_top_sensor_i(top),
        .staple_safety_interlock_i(lock),
        .delivery_belt_home_sensor_i(belt_home),
        .swing_guide_home_sensor_i(guide_home),
        .front_door_closed_i(door),
        .carriage_slide_step_o(slide_step),
        .carriage_slide_rear_o(slide_rear),
        .paddle_motor_step_o(pad_step), .paddle_motor_rev_o(pad_rev),
        .delivery_motor_step_o(dlv), .staple_fold_motor_fwd_o(cam_fwd),
        .irq_o(irq_o));
    ssc_mech_model u_mech (
        .clk_i(ref_clk_i), .slide_step_i(slide_step),
        .slide_rear_i(slide_rear), .paddle_step_i(pad_step),
        .paddle_rev_i(pad_rev), .deliv_step_i(dlv), .cam_fwd_i(cam_fwd),
        .cam_stall_i(stall), .carr_home_o(carr_home),
        .cam_home_o(cam_home), .lock_o(lock), .belt_home_o(belt_home),
        .guide_home_o(guide_home));
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : rd
    task automatic wait_st(input logic [3:0] s, input int lim);
        int          n;
        logic [31:0] v;
        n = 0;
        do
        begin
            rd(`SSC_OFF_STATUS, 0, 0);
            @(negedge ref_clk_i);
            v = last_rd;
            @(posedge ref_clk_i);
            n++;
        end while (v[3:0] !== s && n < lim);
        chk("state", v[3:0], s);
    endtask : wait_st
    task automatic irq_at(input logic e);
        @(negedge ref_clk_i);
        chk("irq", irq_o, e);
        @(posedge ref_clk_i);
    endtask : irq_at
    // result watcher: read data, staple positions, interlock
    always @(posedge ref_clk_i)
    begin
        if (rd_d)
        begin
            last_rd = reg_rdata_o;
            if (msk_q[0] != 0)
                chk("rdata", reg_rdata_o & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        else if (rst_b_i)
            chk("rdata_idle", reg_rdata_o, 0);
        if (fwd_d && !cam_fwd && stap_q.size() == 0)
            chk("staple_extra", 1, 0);
        else if (fwd_d && !cam_fwd)
            chk("staple_pos", u_mech.pos, stap_q.pop_front());
        if (cam_fwd)
            chk("interlock", lock, 1);
        rd_d <= reg_rd_i;
        fwd_d <= cam_fwd;
    end
    initial
    begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        #800000;
        n_errors++;
        end_of_test;
    end
    initial
    begin
        seed = 32'h34022761;
        {rst_b_i, reg_wr_i, reg_rd_i, empty, top, stall} = 6'h00;
        {rd_d, fwd_d, door} = 3'b001;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        repeat (8) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        @(posedge ref_clk_i);
        foreach (offs[i])
            rd(offs[i], vals[i], 32'hFFFFFFFF);
        wr(8'h3C, 32'hFFFF);
        rd(8'h3C, 32'h0, 32'hFFFFFFFF);
        belt_n = 3 + {$random(seed)} % 6;
        wr(`SSC_OFF_FRONT, 32'h0064);
        wr(`SSC_OFF_DBL_REAR, 32'h00C8);
        wr(`SSC_OFF_DBL_FRONT, 32'h0032);
        wr(`SSC_OFF_BELT, belt_n);
        rd(`SSC_OFF_BELT, belt_n, 32'hFFFFFFFF);
        wait_st(ST_READY, 1000);
        chk("homes", u_mech.homes, 1);
        chk("overrun", u_mech.min_pos >= -1, 1);
        chk("standby", u_mech.pos, 256);
        top <= 1'($random(seed));
        empty <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        rd(`SSC_OFF_STATUS, {23'h0, 3'b010, top, 5'h12},
           32'h1FF);
        rd(`SSC_OFF_IRQ_STAT, 32'h4, 32'h4);
        empty <= 1'b0;
        wr(`SSC_OFF_IRQ_STAT, 32'h7);
        rd(`SSC_OFF_IRQ_STAT, 32'h0, 32'h7);
        for (int m = 0; m < 4; m++)
        begin
            stap_q.push_back(pos1[m]);
            if (m > 1)
                stap_q.push_back(50);
            d0 = u_mech.dsteps;
            wr(`SSC_OFF_CTRL, {29'h0, 2'(m), 1'b1});
            repeat (4) @(posedge ref_clk_i);
            wait_st(ST_READY, 2000);
            chk("pos", u_mech.pos, 256);
            chk("staples", stap_q.size(), 0);
            chk("deliv", u_mech.dsteps - d0 >= belt_n + 2, 1);
            chk("guide", guide_home, 1);
            rd(`SSC_OFF_IRQ_STAT, 32'h1, 32'h1);
            if (m == 0)
            begin
                irq_at(1'b0);
                wr(`SSC_OFF_IRQ_MASK, 32'h3);
                irq_at(1'b1);
            end
            wr(`SSC_OFF_IRQ_STAT, 32'h1);
            irq_at(1'b0);
        end
        wr(`SSC_OFF_TIMEOUT, 32'h8);
        stap_q.push_back(256);
        stap_q.push_back(256);
        wr(`SSC_OFF_CTRL, 32'h1);
        @(negedge cam_home);
        stall <= 1'b1;
        wait_st(ST_ERR, 500);
        rd(`SSC_OFF_STATUS, 32'h10E, 32'h10F);
        irq_at(1'b1);
        chk("motor_off", cam_fwd, 0);
        stall <= 1'b0;
        wr(`SSC_OFF_TIMEOUT, 32'h1000);
        wr(`SSC_OFF_CTRL, 32'h8);
        wait_st(ST_READY, 1000);
        repeat (60) @(posedge ref_clk_i);
        chk("rehome", u_mech.homes, 2);
        chk("cam_home", cam_home, 1);
        chk("staples2", stap_q.size(), 0);
        door <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        door <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        wait_st(ST_READY, 1000);
        chk("door_home", u_mech.homes, 3);
        chk("standby2", u_mech.pos, 256);
        end_of_test;
    end
endmodule : tb_stapler_sequence_control
`default_nettype wire
